// [rtl/dma_channel_armed_flag_pkg.sv]
// Constants and types of the channel trigger and descriptor control.
package dma_channel_armed_flag_pkg;
    localparam int NUM_CH = 22;
    localparam logic [11:0] STAT_BASE = 12'h404;
    localparam logic [11:0] CFG_BASE = 12'h408;
    localparam logic [11:0] CH_STRIDE = 12'h004;
    localparam logic [11:0] VALIDATE_OFS = 12'h020;
    localparam logic [11:0] ARMED_SUM_OFS = 12'h600;
    localparam logic [11:0] PEND_SUM_OFS = 12'h604;
    localparam logic [11:0] FLAG_A_OFS = 12'h608;
    localparam logic [11:0] FLAG_B_OFS = 12'h60c;
    localparam logic [11:0] SETUP_BASE = 12'h800;
    localparam logic [11:0] RELOAD_BASE = 12'ha00;
    localparam int CFG_VALID_BIT = 0;
    localparam int CFG_RELOAD_BIT = 1;
    localparam int CFG_SWSTART_BIT = 2;
    localparam int CFG_CLEAR_BIT = 3;
    localparam int CFG_REQ_A_BIT = 4;
    localparam int CFG_REQ_B_BIT = 5;
    localparam int CNT_LSB = 16;
    localparam int CNT_W = 10;
    localparam logic [31:0] CFG_RW_MASK = 32'h03fff33f;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_ARMED_BIT = 2;
    localparam int SU_HWEN_BIT = 1;
    localparam int SU_POL_BIT = 4;
    localparam int SU_KIND_BIT = 5;
    localparam int SU_BURST_BIT = 6;
    localparam int SU_EXP_LSB = 8;
    localparam int SU_SRCWRAP_BIT = 14;
    localparam int SU_DSTWRAP_BIT = 15;
    localparam logic [31:0] SU_RW_MASK = 32'h0000cf72;
    localparam logic [31:0] SU_RESET = 32'h00000000;
    localparam logic [3:0] EXP_MAX = 4'ha;
    typedef enum {ST_RUN, ST_RELOAD} eng_state_type;
endpackage

// [rtl/ctrl_ifs.sv]
// Interfaces between the controller and its trigger sensing and store.
interface channel_armed_flag_sense_if;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] hw_en;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] kind;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] pol;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] hit;
    modport ctrl (output hw_en, output kind, output pol, input hit);
    modport sense (input hw_en, input kind, input pol, output hit);
endinterface

interface reload_if;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [4:0] rd_addr;
    logic [31:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
        output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data,
        input rd_addr, output rd_data);
endinterface

// [rtl/reload_store.sv]
// Per-channel store of the next descriptor used on reload.
module reload_store #(
    parameter int DEPTH = dma_channel_armed_flag_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Store port
    reload_if.store rif
);
    logic [31:0] mem [DEPTH];
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd_ff;

    always_comb begin
        nxt_rd_ff = mem[rif.rd_addr];
    end

    always_ff @(posedge ref_clk) begin
        if (rif.wr_en) begin
            mem[rif.wr_addr] <= rif.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= nxt_rd_ff;
        end
    end

    assign rif.rd_data = rd_ff;
endmodule

// [rtl/channel_armed_flag_sense.sv]
// Synchronises trigger pins and turns them into per-channel trigger hits.
module channel_armed_flag_sense #(
    parameter int NUM = dma_channel_armed_flag_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Trigger pins
    input wire logic [NUM-1:0] channel_armed_flag_pin,
    // Controller side
    channel_armed_flag_sense_if.sense sif
);
    logic [NUM-1:0] s1_ff, s2_ff, s3_ff, stable_ff, prev_ff;
    logic [NUM-1:0] nxt_s1_ff, nxt_s2_ff, nxt_s3_ff;
    logic [NUM-1:0] nxt_stable_ff, nxt_prev_ff;

    // A level is accepted only once the second and third stages agree.
    always_comb begin
        nxt_s1_ff = channel_armed_flag_pin;
        nxt_s2_ff = s1_ff;
        nxt_s3_ff = s2_ff;
        nxt_stable_ff = (~(s2_ff ^ s3_ff) & s3_ff) |
            ((s2_ff ^ s3_ff) & stable_ff);
        nxt_prev_ff = stable_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_ff <= '0;
            prev_ff <= '0;
        end else begin
            s1_ff <= nxt_s1_ff;
            s2_ff <= nxt_s2_ff;
            s3_ff <= nxt_s3_ff;
            stable_ff <= nxt_stable_ff;
            prev_ff <= nxt_prev_ff;
        end
    end

    for (genvar i = 0; i < NUM; i++) begin : g_ch
        logic rise, fall, lvl;
        assign rise = stable_ff[i] & ~prev_ff[i];
        assign fall = ~stable_ff[i] & prev_ff[i];
        assign lvl = (stable_ff[i] == sif.pol[i]);
        assign sif.hit[i] = sif.hw_en[i] &
            (sif.kind[i] ? lvl : (sif.pol[i] ? rise : fall));
    end
endmodule

// [rtl/dma_chan_ctrl.sv]
// Per-channel trigger, status and descriptor control of the DMA engine.
module dma_chan_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Hardware trigger pins
    input wire logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] channel_armed_flag_pin,
    // Transfer issue
    output logic xfer_valid,
    output logic [4:0] xfer_chan,
    output logic xfer_src_wrap,
    output logic xfer_dst_wrap,
    output logic xfer_last,
    // Completion flags
    output logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] flag_a,
    output logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] flag_b
);
    localparam int N = dma_channel_armed_flag_pkg::NUM_CH;
    localparam int CL = dma_channel_armed_flag_pkg::CNT_LSB;
    localparam int CW = dma_channel_armed_flag_pkg::CNT_W;

    channel_armed_flag_sense_if sif ();
    reload_if rif ();

    logic [31:0] cfg_ff [N];
    logic [31:0] nxt_cfg_ff [N];
    logic [31:0] setup_ff [N];
    logic [31:0] nxt_setup_ff [N];
    logic [9:0] bcnt_ff [N];
    logic [9:0] nxt_bcnt_ff [N];
    logic [N-1:0] armed_ff, pend_ff, fla_ff, flb_ff;
    logic [N-1:0] nxt_armed_ff, nxt_pend_ff, nxt_fla_ff, nxt_flb_ff;
    logic [N-1:0] arm_set, arm_clr, pend_set, pend_clr;
    logic [N-1:0] fa_set, fb_set, fa_clr, fb_clr;
    dma_channel_armed_flag_pkg::eng_state_type state_ff, nxt_state_ff;
    logic [4:0] rl_ch_ff, nxt_rl_ch_ff;
    logic [31:0] rd_data_ff, nxt_rd_data_ff;
    logic xv_ff, sw_ff, dw_ff, last_ff;
    logic nxt_xv_ff, nxt_sw_ff, nxt_dw_ff, nxt_last_ff;
    logic [4:0] xch_ff, nxt_xch_ff;
    logic go, exh, blast;
    logic [4:0] sel;
    logic [CW-1:0] cnt;
    logic [31:0] su;
    logic [5:0] wc, ws, wu, wr;

    // Returns {hit, channel} for a per-channel register window.
    function automatic logic [5:0] win(input logic [11:0] a,
            input logic [11:0] base);
        logic [11:0] d;
        logic ok;
        d = a - base;
        ok = (a >= base) && (d % dma_channel_armed_flag_pkg::CH_STRIDE == 12'h000) &&
            (d / dma_channel_armed_flag_pkg::CH_STRIDE < 12'(N));
        return {ok, 5'(d / dma_channel_armed_flag_pkg::CH_STRIDE)};
    endfunction

    // Last transfer index inside a burst; larger codes act as the largest.
    function automatic logic [9:0] burst_last(input logic [3:0] e);
        logic [3:0] c;
        c = (e > dma_channel_armed_flag_pkg::EXP_MAX) ? dma_channel_armed_flag_pkg::EXP_MAX : e;
        return 10'((11'h001 << c) - 11'h001);
    endfunction

    assign wc = win(addr, dma_channel_armed_flag_pkg::CFG_BASE);
    assign ws = win(addr, dma_channel_armed_flag_pkg::STAT_BASE);
    assign wu = win(addr, dma_channel_armed_flag_pkg::SETUP_BASE);
    assign wr = win(addr, dma_channel_armed_flag_pkg::RELOAD_BASE);

    channel_armed_flag_sense #(.NUM(N)) u_sense (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .channel_armed_flag_pin(channel_armed_flag_pin),
        .sif(sif.ctrl)
    );

    reload_store #(.DEPTH(N)) u_store (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rif(rif.store)
    );

    always_comb begin
        for (int i = 0; i < N; i++) begin
            sif.hw_en[i] = setup_ff[i][dma_channel_armed_flag_pkg::SU_HWEN_BIT];
            sif.kind[i] = setup_ff[i][dma_channel_armed_flag_pkg::SU_KIND_BIT];
            sif.pol[i] = setup_ff[i][dma_channel_armed_flag_pkg::SU_POL_BIT];
        end
    end

    assign rif.wr_en = wr_en && wr[5];
    assign rif.wr_addr = wr[4:0];
    assign rif.wr_data = wr_data & dma_channel_armed_flag_pkg::CFG_RW_MASK;
    assign rif.rd_addr = sel;

    // Lowest numbered armed channel with a valid descriptor is served.
    always_comb begin
        go = 1'b0;
        sel = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (armed_ff[i] && cfg_ff[i][dma_channel_armed_flag_pkg::CFG_VALID_BIT]) begin
                go = (state_ff == dma_channel_armed_flag_pkg::ST_RUN);
                sel = 5'(i);
            end
        end
        cnt = cfg_ff[sel][CL +: CW];
        su = setup_ff[sel];
        exh = (cnt == '0);
        blast = (bcnt_ff[sel] ==
            burst_last(su[dma_channel_armed_flag_pkg::SU_EXP_LSB +: 4]));
    end

    always_comb begin
        nxt_cfg_ff = cfg_ff;
        nxt_setup_ff = setup_ff;
        nxt_bcnt_ff = bcnt_ff;
        nxt_state_ff = state_ff;
        nxt_rl_ch_ff = rl_ch_ff;
        arm_set = sif.hit;
        arm_clr = '0;
        pend_set = '0;
        pend_clr = '0;
        fa_set = '0;
        fb_set = '0;
        fa_clr = '0;
        fb_clr = '0;
        nxt_xv_ff = go;
        nxt_xch_ff = sel;
        nxt_sw_ff = 1'b0;
        nxt_dw_ff = 1'b0;
        nxt_last_ff = go && exh;
        if (go) begin
            // Wrapping restarts the address range at each burst end.
            nxt_sw_ff = blast && su[dma_channel_armed_flag_pkg::SU_SRCWRAP_BIT];
            nxt_dw_ff = blast && su[dma_channel_armed_flag_pkg::SU_DSTWRAP_BIT];
            nxt_bcnt_ff[sel] = (blast || exh) ? 10'h000 :
                bcnt_ff[sel] + 10'h001;
            if (!exh) begin
                nxt_cfg_ff[sel][CL +: CW] = cnt - 10'h001;
            end
            if (blast && !exh && su[dma_channel_armed_flag_pkg::SU_BURST_BIT]) begin
                arm_clr[sel] = 1'b1;
            end
            if (exh) begin
                fa_set[sel] = cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_REQ_A_BIT];
                fb_set[sel] = cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_REQ_B_BIT];
                if (cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_RELOAD_BIT]) begin
                    nxt_state_ff = dma_channel_armed_flag_pkg::ST_RELOAD;
                    nxt_rl_ch_ff = sel;
                    // Cleared, the next descriptor starts untriggered unless its own software start bit arms it on reload.
                    if (cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_CLEAR_BIT]) begin
                        arm_clr[sel] = 1'b1;
                    end
                end else begin
                    nxt_cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_VALID_BIT] = 1'b0;
                    arm_clr[sel] = 1'b1;
                end
            end
        end else if (state_ff == dma_channel_armed_flag_pkg::ST_RELOAD) begin
            nxt_cfg_ff[rl_ch_ff] = rif.rd_data;
            nxt_cfg_ff[rl_ch_ff][dma_channel_armed_flag_pkg::CFG_VALID_BIT] =
                rif.rd_data[dma_channel_armed_flag_pkg::CFG_VALID_BIT] | pend_ff[rl_ch_ff];
            pend_clr[rl_ch_ff] = 1'b1;
            if (rif.rd_data[dma_channel_armed_flag_pkg::CFG_SWSTART_BIT]) begin
                arm_set[rl_ch_ff] = 1'b1;
            end
            nxt_state_ff = dma_channel_armed_flag_pkg::ST_RUN;
        end
        // A software write wins over the engine's update of the same word.
        if (wr_en) begin
            if (wc[5]) begin
                nxt_cfg_ff[wc[4:0]] = wr_data & dma_channel_armed_flag_pkg::CFG_RW_MASK;
                if (wr_data[dma_channel_armed_flag_pkg::CFG_SWSTART_BIT]) begin
                    arm_set[wc[4:0]] = 1'b1;
                end
            end else if (addr == dma_channel_armed_flag_pkg::VALIDATE_OFS) begin
                for (int i = 0; i < N; i++) begin
                    if (wr_data[i]) begin
                        if (cfg_ff[i][dma_channel_armed_flag_pkg::CFG_VALID_BIT]) begin
                            pend_set[i] = 1'b1;
                        end else begin
                            nxt_cfg_ff[i][dma_channel_armed_flag_pkg::CFG_VALID_BIT] =
                                1'b1;
                        end
                    end
                end
            end else if (addr == dma_channel_armed_flag_pkg::FLAG_A_OFS) begin
                fa_clr = wr_data[N-1:0];
            end else if (addr == dma_channel_armed_flag_pkg::FLAG_B_OFS) begin
                fb_clr = wr_data[N-1:0];
            end else if (wu[5]) begin
                nxt_setup_ff[wu[4:0]] = wr_data & dma_channel_armed_flag_pkg::SU_RW_MASK;
            end
        end
        // Every hardware set beats a clear arriving in the same cycle.
        nxt_armed_ff = (armed_ff & ~arm_clr) | arm_set;
        nxt_pend_ff = (pend_ff & ~pend_clr) | pend_set;
        nxt_fla_ff = (fla_ff & ~fa_clr) | fa_set;
        nxt_flb_ff = (flb_ff & ~fb_clr) | fb_set;
    end

    // Config decode wins where the two word windows overlap.
    always_comb begin
        nxt_rd_data_ff = 32'h00000000;
        if (!rd_en) begin
            nxt_rd_data_ff = 32'h00000000;
        end else if (wc[5]) begin
            nxt_rd_data_ff = cfg_ff[wc[4:0]];
        end else if (ws[5]) begin
            nxt_rd_data_ff[dma_channel_armed_flag_pkg::STAT_PEND_BIT] = pend_ff[ws[4:0]];
            nxt_rd_data_ff[dma_channel_armed_flag_pkg::STAT_ARMED_BIT] = armed_ff[ws[4:0]];
        end else if (addr == dma_channel_armed_flag_pkg::ARMED_SUM_OFS) begin
            nxt_rd_data_ff[N-1:0] = armed_ff;
        end else if (addr == dma_channel_armed_flag_pkg::PEND_SUM_OFS) begin
            nxt_rd_data_ff[N-1:0] = pend_ff;
        end else if (addr == dma_channel_armed_flag_pkg::FLAG_A_OFS) begin
            nxt_rd_data_ff[N-1:0] = fla_ff;
        end else if (addr == dma_channel_armed_flag_pkg::FLAG_B_OFS) begin
            nxt_rd_data_ff[N-1:0] = flb_ff;
        end else if (wu[5]) begin
            nxt_rd_data_ff = setup_ff[wu[4:0]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_ff <= '{default: dma_channel_armed_flag_pkg::CFG_RESET};
            setup_ff <= '{default: dma_channel_armed_flag_pkg::SU_RESET};
            bcnt_ff <= '{default: 10'h000};
            armed_ff <= '0;
            pend_ff <= '0;
            fla_ff <= '0;
            flb_ff <= '0;
            state_ff <= dma_channel_armed_flag_pkg::ST_RUN;
            rl_ch_ff <= 5'h00;
            rd_data_ff <= 32'h00000000;
            xv_ff <= 1'b0;
            xch_ff <= 5'h00;
            sw_ff <= 1'b0;
            dw_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg_ff;
            setup_ff <= nxt_setup_ff;
            bcnt_ff <= nxt_bcnt_ff;
            armed_ff <= nxt_armed_ff;
            pend_ff <= nxt_pend_ff;
            fla_ff <= nxt_fla_ff;
            flb_ff <= nxt_flb_ff;
            state_ff <= nxt_state_ff;
            rl_ch_ff <= nxt_rl_ch_ff;
            rd_data_ff <= nxt_rd_data_ff;
            xv_ff <= nxt_xv_ff;
            xch_ff <= nxt_xch_ff;
            sw_ff <= nxt_sw_ff;
            dw_ff <= nxt_dw_ff;
            last_ff <= nxt_last_ff;
        end
    end

    assign rd_data = rd_data_ff;
    assign xfer_valid = xv_ff;
    assign xfer_chan = xch_ff;
    assign xfer_src_wrap = sw_ff;
    assign xfer_dst_wrap = dw_ff;
    assign xfer_last = last_ff;
    assign flag_a = fla_ff;
    assign flag_b = flb_ff;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_hit_arms: assert property (
        sif.hit != '0 |=> (armed_ff & $past(sif.hit)) == $past(sif.hit))
        else $error("Trigger hit did not arm its channel.");
    a_issue_armed: assert property (
        go |-> armed_ff[sel] && cfg_ff[sel][0] ##1
            xfer_valid && xfer_chan == $past(sel))
        else $error("Transfer issued on an unarmed or invalid channel.");
    a_pend_set: assert property (
        wr_en && addr == dma_channel_armed_flag_pkg::VALIDATE_OFS && wr_data[0] &&
            cfg_ff[0][0] |=> pend_ff[0])
        else $error("Validation waiting flag not set.");
    a_sw_arms: assert property (
        wr_en && wc == 6'h20 && wr_data[2] |=> armed_ff[0])
        else $error("Software start did not arm channel 0.");
    a_flag_a_set: assert property (
        go && exh && cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_REQ_A_BIT] |=>
            flag_a[xfer_chan] && xfer_last)
        else $error("Flag A not set on exhaustion.");
    a_clear_drops: assert property (
        go && exh && cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_CLEAR_BIT] &&
            !sif.hit[sel] && !wr_en |=> !armed_ff[xfer_chan])
        else $error("Armed flag kept despite clear on exhaustion.");
    a_keep_armed: assert property (
        go && exh && !cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_CLEAR_BIT] &&
            cfg_ff[sel][dma_channel_armed_flag_pkg::CFG_RELOAD_BIT] |=>
            armed_ff[xfer_chan] && state_ff == dma_channel_armed_flag_pkg::ST_RELOAD ##1
            state_ff == dma_channel_armed_flag_pkg::ST_RUN)
        else $error("Chained descriptor lost its armed flag.");
    a_count_down: assert property (
        go && !exh && !wr_en |=>
            cfg_ff[xfer_chan][CL +: CW] == $past(cnt) - 10'h001)
        else $error("Transfer count did not step down by one.");
    a_burst_stop: assert property (
        go && su[dma_channel_armed_flag_pkg::SU_BURST_BIT] && blast && !exh &&
            !sif.hit[sel] && !wr_en |=> !armed_ff[xfer_chan])
        else $error("Burst end did not disarm its channel.");
    c_reload: cover property (state_ff == dma_channel_armed_flag_pkg::ST_RELOAD);
    c_burst_wrap: cover property (xfer_src_wrap && !xfer_last);
    c_flag_b: cover property ($rose(flag_b[0]));
endmodule

// [test/channel_armed_flag_source_model.sv]
// Behavioural model of the peripheral trigger sources at the pins.
module channel_armed_flag_source_model (
    // Clock
    input wire logic ref_clk,
    // Levels the bench asks for
    input wire logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] level_req,
    // Trigger pins
    output logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] channel_armed_flag_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial channel_armed_flag_pin = '0;
    // A peripheral moves its request only after its own clock edge.
    always @(posedge ref_clk) begin
        channel_armed_flag_pin <= level_req;
    end
endmodule

// [test/dma_channel_trigger_descriptor_control_test.sv]
// Self-checking bench of the channel trigger and descriptor control.
module dma_channel_trigger_descriptor_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wr_data = 32'h00000000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] level_req = '0;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] channel_armed_flag_pin;
    logic xfer_valid;
    logic [4:0] xfer_chan;
    logic xfer_src_wrap;
    logic xfer_dst_wrap;
    logic xfer_last;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] flag_a;
    logic [dma_channel_armed_flag_pkg::NUM_CH-1:0] flag_b;
    int num_errors = 0;
    int tests_run = 0;
    int n_xfer;
    int n_wrap;
    int n_dwrap;
    int n_last;
    logic [31:0] rv;

    always #25 ref_clk = ~ref_clk;

    dma_chan_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .channel_armed_flag_pin(channel_armed_flag_pin), .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
        .xfer_src_wrap(xfer_src_wrap), .xfer_dst_wrap(xfer_dst_wrap),
        .xfer_last(xfer_last), .flag_a(flag_a), .flag_b(flag_b));
    channel_armed_flag_source_model src (.ref_clk(ref_clk), .level_req(level_req),
        .channel_armed_flag_pin(channel_armed_flag_pin));

    task automatic check(input string name, input logic [31:0] got,
        input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Reserved bits are always written as zero by these tasks' callers.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        d = rd_data;
    endtask

    function automatic logic [11:0] cfg_a(input int ch);
        return dma_channel_armed_flag_pkg::CFG_BASE + 12'(4 * ch);
    endfunction

    // Counts the transfers of one channel over a span of cycles.
    task automatic collect(input int ch, input int cycles);
        n_xfer = 0;
        n_wrap = 0;
        n_dwrap = 0;
        n_last = 0;
        repeat (cycles) begin
            @(negedge ref_clk);
            if (xfer_valid === 1'b1 && xfer_chan === 5'(ch)) begin
                n_xfer++;
                n_wrap += int'(xfer_src_wrap === 1'b1);
                n_dwrap += int'(xfer_dst_wrap === 1'b1);
                n_last += int'(xfer_last === 1'b1);
            end
        end
    endtask

    task automatic t_reset();
        rd(cfg_a(5), rv);
        check("config reset", rv, 32'h00000000);
        rd(12'h600, rv);
        check("armed reset", rv, 32'h00000000);
        rd(12'h604, rv);
        check("waiting reset", rv, 32'h00000000);
        wr(cfg_a(5), 32'h03ff0002);
        rd(cfg_a(5), rv);
        check("config readback", rv, 32'h03ff0002);
        rd(12'h100, rv);
        check("unmapped read", rv, 32'h00000000);
        $display("reset test done");
    endtask

    task automatic t_single();
        wr(cfg_a(0), 32'h00000015);
        collect(0, 6);
        check("single count", 32'(n_xfer), 32'h00000001);
        check("single last", 32'(n_last), 32'h00000001);
        check("flag a pin", 32'(flag_a[0]), 32'h00000001);
        rd(12'h600, rv);
        check("armed after end", rv, 32'h00000000);
        wr(12'h608, 32'h00000001);
        rd(12'h608, rv);
        check("flag a cleared", rv, 32'h00000000);
        $display("single test done");
    endtask

    task automatic t_valid();
        wr(cfg_a(1), 32'h00000004);
        collect(1, 6);
        check("invalid idle", 32'(n_xfer), 32'h00000000);
        wr(dma_channel_armed_flag_pkg::VALIDATE_OFS, 32'h00000002);
        collect(1, 6);
        check("validated run", 32'(n_xfer), 32'h00000001);
        wr(cfg_a(0), 32'h00000001);
        wr(dma_channel_armed_flag_pkg::VALIDATE_OFS, 32'h00000001);
        rd(dma_channel_armed_flag_pkg::STAT_BASE, rv);
        check("waiting status", rv, 32'h00000001);
        rd(dma_channel_armed_flag_pkg::PEND_SUM_OFS, rv);
        check("waiting summary", rv, 32'h00000001);
        $display("valid test done");
    endtask

    task automatic t_count();
        wr(cfg_a(2), 32'h00030025);
        collect(2, 10);
        check("count xfers", 32'(n_xfer), 32'h00000004);
        check("count last", 32'(n_last), 32'h00000001);
        check("flag b pin", 32'(flag_b[2]), 32'h00000001);
        wr(dma_channel_armed_flag_pkg::FLAG_B_OFS, 32'h00000004);
        rd(dma_channel_armed_flag_pkg::FLAG_B_OFS, rv);
        check("flag b cleared", rv, 32'h00000000);
        $display("count test done");
    endtask

    task automatic t_reload();
        wr(dma_channel_armed_flag_pkg::RELOAD_BASE + 12'h018, 32'h00010001);
        wr(cfg_a(6), 32'h00000007);
        collect(6, 10);
        check("chain xfers", 32'(n_xfer), 32'h00000003);
        check("chain lasts", 32'(n_last), 32'h00000002);
        wr(dma_channel_armed_flag_pkg::RELOAD_BASE + 12'h01c, 32'h00000001);
        wr(cfg_a(7), 32'h0000000f);
        collect(7, 8);
        check("clear xfers", 32'(n_xfer), 32'h00000001);
        rd(12'h600, rv);
        check("clear armed", rv & 32'h000000c0, 32'h00000000);
        $display("reload test done");
    endtask

    task automatic t_burst();
        wr(dma_channel_armed_flag_pkg::SETUP_BASE + 12'h020, 32'h00004140);
        wr(cfg_a(8), 32'h00030005);
        collect(8, 12);
        check("burst xfers", 32'(n_xfer), 32'h00000002);
        check("burst wraps", 32'(n_wrap), 32'h00000001);
        check("burst last", 32'(n_last), 32'h00000000);
        check("burst dst wraps", 32'(n_dwrap), 32'h00000000);
        wr(dma_channel_armed_flag_pkg::SETUP_BASE + 12'h024, 32'h0000c100);
        wr(cfg_a(9), 32'h00030005);
        collect(9, 12);
        check("wrap xfers", 32'(n_xfer), 32'h00000004);
        check("wrap count", 32'(n_wrap), 32'h00000002);
        check("dst wrap count", 32'(n_dwrap), 32'h00000002);
        $display("burst test done");
    endtask

    // Each sense mode gets a fresh channel so no stale arming leaks.
    task automatic t_hw();
        int ch;
        logic pol;
        for (int m = 0; m < 4; m++) begin
            ch = 10 + m;
            pol = m[0];
            @(posedge ref_clk);
            level_req[ch] <= ~pol;
            repeat (8) @(posedge ref_clk);
            wr(dma_channel_armed_flag_pkg::SETUP_BASE + 12'(4 * ch),
                32'h00000002 | (32'(pol) << 4) | (32'(m[1]) << 5));
            wr(cfg_a(ch), 32'h00000001);
            collect(ch, 10);
            check("hw idle", 32'(n_xfer), 32'h00000000);
            @(posedge ref_clk);
            level_req[ch] <= pol;
            collect(ch, 14);
            check("hw hit", 32'(n_xfer), 32'h00000001);
        end
        $display("hardware trigger test done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_valid();
        t_count();
        t_reload();
        t_burst();
        t_hw();
        finish_test();
    end

    initial begin
        repeat (6000) @(posedge ref_clk);
        num_errors++;
        $display("ERROR watchdog expected done seen timeout");
        finish_test();
    end
endmodule
